// ---- hdl/pwr_seq_pkg.sv ----
package pwr_seq_pkg;

    // Timebase: one tick per microsecond at the 125 MHz system clock
    localparam int CLK_PERIOD_NS = 8;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam logic [6:0] TICK_LAST = 7'(TICK_CYCLES - 1);

    // Programmable window for both timers, in microsecond ticks
    localparam int MIN_TIME_US = 250;
    localparam int MAX_TIME_US = 25000;
    localparam int TIME_W = 15;
    localparam logic [TIME_W-1:0] MIN_TIME_TICKS = TIME_W'(MIN_TIME_US);
    localparam logic [TIME_W-1:0] MAX_TIME_TICKS = TIME_W'(MAX_TIME_US);
    localparam logic [TIME_W-1:0] TIMER_SAT = 15'h7FFF;

    localparam int NUM_CH = 4;
    localparam int IRQ_W = 4;

    // Register byte offsets
    localparam logic [7:0] ADDR_STEP_DELAY = 8'h00;
    localparam logic [7:0] ADDR_REG_TIMEOUT = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

    // Reset values: zero means unconfigured (no delay, timeout check off)
    localparam logic [TIME_W-1:0] STEP_DELAY_RST = 15'h0000;
    localparam logic [TIME_W-1:0] REG_TIMEOUT_RST = 15'h0000;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

    // Interrupt bit positions
    localparam int IRQ_UP_DONE = 0;
    localparam int IRQ_DOWN_DONE = 1;
    localparam int IRQ_FAULT = 2;
    localparam int IRQ_GOOD_LOST = 3;

    // Status register fields
    localparam int ST_STATE_LSB = 0;
    localparam int ST_CH_LSB = 4;
    localparam int ST_EN_LSB = 8;
    localparam int ST_MON_LSB = 12;
    localparam int ST_DONE_BIT = 16;
    localparam int ST_GOOD_BIT = 17;
    localparam int ST_FAULT_BIT = 18;

    typedef enum logic [2:0] {
        SEQ_OFF,
        SEQ_UP_WAIT,
        SEQ_UP_STEP,
        SEQ_ON,
        SEQ_DOWN_STEP,
        SEQ_FAULT
    } seq_state_t;

endpackage

// ---- hdl/four_rail_power_sequencer.sv ----
// Functional notes
// [RULE1] Rising edge of the power-on request starts the power-up sequence.
// [RULE2] Falling edge of the power-off request starts the power-down sequence.
// [RULE3] Power-up enables channels 1 to 4 in order, each paired with its monitor.
// [RULE4] Power-down disables channels in reverse order, channel 4 first, channel 1 last.
// [RULE5] One global step delay, 0.25 ms to 25 ms, separates channel transitions.
// [RULE6] An unconfigured step delay setting gives zero delay.
// [RULE7] Each enabled rail gets a 0.25 ms to 25 ms window to regulate.
// [RULE8] An unconfigured regulation timeout setting disables the timeout check.
// [RULE9] A rail counts as regulated while its monitor comparator reads high.
// [RULE10] Sequence-complete flag is raised when power-up or power-down finishes.
// [RULE11] All-rails-good flag is high only while all four monitors read high.
// [RULE12] An internal fault pulls the open-drain fault output low.
// [RULE13] Channel enable outputs are active high.
// [RULE14] Channels 2 to 4 flagged unused are treated as off and skipped.
// [RULE15] Devices may be chained; completion of one can start the next.
// [RULE16] Next channel is enabled only after regulation and the step delay.
// [RULE17] Timeout before regulation stops sequencing and raises the fault.
module four_rail_power_sequencer (
    input logic I_CLOCK,
    input logic I_SYS_RST,
    input logic I_WB_CYC,
    input logic I_WB_STB,
    input logic I_WB_WE,
    input logic [7:0] I_WB_ADR,
    input logic [31:0] I_WB_DAT,
    input logic [3:0] I_WB_SEL,
    output logic [31:0] O_WB_DAT,
    output logic O_WB_ACK,
    input logic I_POWER_ON_REQ,
    input logic I_POWER_OFF_REQ,
    input logic [3:0] I_RAIL_MONITOR_INPUT,
    input logic [2:0] I_CHANNEL_UNUSED,
    output logic [3:0] O_CHANNEL_ENABLE_OUTPUT,
    output logic O_SEQUENCE_COMPLETE_FLAG,
    output logic O_ALL_RAILS_GOOD_FLAG,
    output logic O_FAULT_N_OUT,
    output logic O_FAULT_N_OE,
    output logic O_IRQ
);

    typedef struct packed {
        pwr_seq_pkg::seq_state_t state;
        logic [1:0] ch;
        logic skip;
        logic [6:0] prescale;
        logic [pwr_seq_pkg::TIME_W-1:0] timer;
        logic [pwr_seq_pkg::TIME_W-1:0] step_delay_setting;
        logic [pwr_seq_pkg::TIME_W-1:0] regulation_timeout_setting;
        logic [pwr_seq_pkg::IRQ_W-1:0] irq_status;
        logic [pwr_seq_pkg::IRQ_W-1:0] irq_mask;
        logic on_req_q;
        logic off_req_q;
        logic [pwr_seq_pkg::NUM_CH-1:0] enable;
        logic sequence_complete_flag;
        logic rails_good;
        logic fault;
        logic fault_level;
        logic irq;
        logic ack;
        logic [31:0] rdata;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // Zero stays zero; any other setting is pulled into the legal window
    function automatic logic [pwr_seq_pkg::TIME_W-1:0] clamp_time(
        input logic [pwr_seq_pkg::TIME_W-1:0] v
    );
        logic [pwr_seq_pkg::TIME_W-1:0] r;
        r = v;
        if (v == 15'h0000) begin
            r = 15'h0000;
        end else if (v < pwr_seq_pkg::MIN_TIME_TICKS) begin
            r = pwr_seq_pkg::MIN_TIME_TICKS;
        end else if (v > pwr_seq_pkg::MAX_TIME_TICKS) begin
            r = pwr_seq_pkg::MAX_TIME_TICKS;
        end
        return r;
    endfunction

    always_comb begin
        logic tick;
        logic up_edge;
        logic down_edge;
        logic delay_done;
        logic timeout_hit;
        logic [3:0] chan_off;
        logic [pwr_seq_pkg::TIME_W-1:0] step_ticks;
        logic [pwr_seq_pkg::TIME_W-1:0] timeout_ticks;
        logic [pwr_seq_pkg::IRQ_W-1:0] events;
        logic [pwr_seq_pkg::IRQ_W-1:0] rd_clear;
        logic bus_req;
        logic [1:0] ch_up;
        logic [1:0] ch_dn;
        logic rest_off;

        state_next = state_reg;
        events = '0;
        rd_clear = '0;

        tick = (state_reg.prescale == pwr_seq_pkg::TICK_LAST);
        state_next.prescale = tick ? 7'h00 : 7'(state_reg.prescale + 7'h01);
        if (tick && state_reg.timer != pwr_seq_pkg::TIMER_SAT) begin
            state_next.timer = 15'(state_reg.timer + 15'h0001);
        end

        state_next.on_req_q = I_POWER_ON_REQ;
        state_next.off_req_q = I_POWER_OFF_REQ;
        up_edge = I_POWER_ON_REQ && !state_reg.on_req_q; // see [RULE1]
        down_edge = !I_POWER_OFF_REQ && state_reg.off_req_q; // see [RULE2]

        // Channel 1 can never be marked unused
        chan_off = {I_CHANNEL_UNUSED, 1'b0}; // see [RULE14]

        step_ticks = clamp_time(state_reg.step_delay_setting); // see [RULE5]
        timeout_ticks = clamp_time(state_reg.regulation_timeout_setting); // see [RULE7]
        delay_done = (state_reg.timer >= step_ticks); // see [RULE6]
        timeout_hit = (timeout_ticks != 15'h0000) && // see [RULE8]
                      (state_reg.timer >= timeout_ticks);

        ch_up = 2'(state_reg.ch + 2'h1);
        ch_dn = 2'(state_reg.ch - 2'h1);
        // Every channel above the current one unused: nothing left to step to
        rest_off = &(chan_off | ~(4'hF << ch_up)); // see [RULE14]

        unique case (state_reg.state)
            pwr_seq_pkg::SEQ_OFF: begin
                if (up_edge) begin
                    state_next.sequence_complete_flag = 1'b0;
                    state_next.fault = 1'b0;
                    state_next.ch = 2'h0;
                    state_next.enable[0] = 1'b1; // see [RULE3] [RULE13]
                    state_next.timer = '0;
                    state_next.state = pwr_seq_pkg::SEQ_UP_WAIT;
                end
            end
            pwr_seq_pkg::SEQ_UP_WAIT: begin
                if (chan_off[state_reg.ch] ||
                    I_RAIL_MONITOR_INPUT[state_reg.ch]) begin // see [RULE9]
                    // No trailing step delay after the last used channel
                    if (state_reg.ch == 2'h3 || rest_off) begin
                        state_next.sequence_complete_flag = 1'b1; // see [RULE10] [RULE15]
                        events[pwr_seq_pkg::IRQ_UP_DONE] = 1'b1;
                        state_next.state = pwr_seq_pkg::SEQ_ON;
                    end else if (chan_off[state_reg.ch]) begin
                        // Unused channel: no delay spent on it
                        state_next.ch = ch_up; // see [RULE14]
                        state_next.enable[ch_up] = !chan_off[ch_up];
                        state_next.timer = '0;
                    end else begin
                        state_next.timer = '0;
                        state_next.state = pwr_seq_pkg::SEQ_UP_STEP;
                    end
                end else if (timeout_hit) begin
                    state_next.fault = 1'b1; // see [RULE17]
                    events[pwr_seq_pkg::IRQ_FAULT] = 1'b1;
                    state_next.state = pwr_seq_pkg::SEQ_FAULT;
                end
            end
            pwr_seq_pkg::SEQ_UP_STEP: begin
                if (delay_done) begin // see [RULE16]
                    state_next.ch = ch_up; // see [RULE3]
                    state_next.enable[ch_up] = !chan_off[ch_up];
                    state_next.timer = '0;
                    state_next.state = pwr_seq_pkg::SEQ_UP_WAIT;
                end
            end
            pwr_seq_pkg::SEQ_ON: begin
            end
            pwr_seq_pkg::SEQ_DOWN_STEP: begin
                if (state_reg.ch == 2'h0) begin
                    state_next.sequence_complete_flag = 1'b1; // see [RULE10]
                    events[pwr_seq_pkg::IRQ_DOWN_DONE] = 1'b1;
                    state_next.state = pwr_seq_pkg::SEQ_OFF;
                end else if (delay_done || state_reg.skip) begin // see [RULE5]
                    state_next.ch = ch_dn; // see [RULE4]
                    state_next.skip = !state_reg.enable[ch_dn];
                    state_next.enable[ch_dn] = 1'b0;
                    state_next.timer = '0;
                end
            end
            pwr_seq_pkg::SEQ_FAULT: begin
                // Holds the enables where they stood until powered down
            end
        endcase

        // A power-down may abort a power-up or leave the fault state
        if (down_edge && state_reg.state != pwr_seq_pkg::SEQ_OFF &&
            state_reg.state != pwr_seq_pkg::SEQ_DOWN_STEP) begin
            state_next.sequence_complete_flag = 1'b0;
            state_next.ch = 2'h3;
            state_next.skip = !state_reg.enable[3];
            state_next.enable[3] = 1'b0; // see [RULE4]
            state_next.timer = '0;
            state_next.state = pwr_seq_pkg::SEQ_DOWN_STEP;
        end

        state_next.rails_good = &I_RAIL_MONITOR_INPUT; // see [RULE11]
        if (state_reg.rails_good && !state_next.rails_good) begin
            events[pwr_seq_pkg::IRQ_GOOD_LOST] = 1'b1;
        end
        state_next.fault_level = 1'b0; // see [RULE12]

        // Wishbone classic slave, one wait state, ack for one cycle
        bus_req = I_WB_CYC && I_WB_STB && !state_reg.ack;
        state_next.ack = bus_req;
        state_next.rdata = 32'h0000_0000;
        if (bus_req && I_WB_WE) begin
            unique case ({I_WB_ADR[7:2], 2'b00})
                pwr_seq_pkg::ADDR_STEP_DELAY: begin
                    if (I_WB_SEL[0]) state_next.step_delay_setting[7:0] = I_WB_DAT[7:0];
                    if (I_WB_SEL[1]) state_next.step_delay_setting[14:8] = I_WB_DAT[14:8];
                end
                pwr_seq_pkg::ADDR_REG_TIMEOUT: begin
                    if (I_WB_SEL[0]) begin
                        state_next.regulation_timeout_setting[7:0] = I_WB_DAT[7:0];
                    end
                    if (I_WB_SEL[1]) begin
                        state_next.regulation_timeout_setting[14:8] = I_WB_DAT[14:8];
                    end
                end
                pwr_seq_pkg::ADDR_IRQ_MASK: begin
                    if (I_WB_SEL[0]) state_next.irq_mask = I_WB_DAT[3:0];
                end
                default: begin
                end
            endcase
        end else if (bus_req) begin
            unique case ({I_WB_ADR[7:2], 2'b00})
                pwr_seq_pkg::ADDR_STEP_DELAY: begin
                    state_next.rdata[14:0] = state_reg.step_delay_setting;
                end
                pwr_seq_pkg::ADDR_REG_TIMEOUT: begin
                    state_next.rdata[14:0] = state_reg.regulation_timeout_setting;
                end
                pwr_seq_pkg::ADDR_STATUS: begin
                    state_next.rdata[pwr_seq_pkg::ST_STATE_LSB +: 3] = state_reg.state;
                    state_next.rdata[pwr_seq_pkg::ST_CH_LSB +: 2] = state_reg.ch;
                    state_next.rdata[pwr_seq_pkg::ST_EN_LSB +: 4] = state_reg.enable;
                    state_next.rdata[pwr_seq_pkg::ST_MON_LSB +: 4] = I_RAIL_MONITOR_INPUT;
                    state_next.rdata[pwr_seq_pkg::ST_DONE_BIT] = state_reg.sequence_complete_flag;
                    state_next.rdata[pwr_seq_pkg::ST_GOOD_BIT] = state_reg.rails_good;
                    state_next.rdata[pwr_seq_pkg::ST_FAULT_BIT] = state_reg.fault;
                end
                pwr_seq_pkg::ADDR_IRQ_STATUS: begin
                    state_next.rdata[3:0] = state_reg.irq_status;
                    rd_clear = state_reg.irq_status;
                end
                pwr_seq_pkg::ADDR_IRQ_MASK: begin
                    state_next.rdata[3:0] = state_reg.irq_mask;
                end
                default: begin
                end
            endcase
        end

        // An event in the same cycle as the clearing read survives
        state_next.irq_status = (state_reg.irq_status & ~rd_clear) | events;
        state_next.irq = |(state_next.irq_status & state_next.irq_mask);
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
            state_reg <= '0;
            state_reg.state <= pwr_seq_pkg::SEQ_OFF;
            state_reg.step_delay_setting <= pwr_seq_pkg::STEP_DELAY_RST;
            state_reg.regulation_timeout_setting <= pwr_seq_pkg::REG_TIMEOUT_RST;
            state_reg.irq_mask <= pwr_seq_pkg::IRQ_MASK_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    assign O_WB_DAT = state_reg.rdata;
    assign O_WB_ACK = state_reg.ack;
    assign O_CHANNEL_ENABLE_OUTPUT = state_reg.enable;
    assign O_SEQUENCE_COMPLETE_FLAG = state_reg.sequence_complete_flag;
    assign O_ALL_RAILS_GOOD_FLAG = state_reg.rails_good;
    assign O_FAULT_N_OUT = state_reg.fault_level;
    assign O_FAULT_N_OE = state_reg.fault; // see [RULE12]
    assign O_IRQ = state_reg.irq;

endmodule

// ---- testbench/rail_model.sv ----
module rail_model #(
    parameter int RAMP = 20
) (
    input wire logic i_clk,
    input wire logic [3:0] i_en,
    input wire logic [2:0] i_unused,
    input wire logic [3:0] i_stuck,
    output logic [3:0] o_mon
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt [4] = '{default: 0};
    always @(posedge i_clk) begin
        for (int i = 0; i < 4; i++) begin
            // Regulator ramps only while its enable is high; stuck ones never regulate
            if (!i_en[i]) begin
                cnt[i] <= 0;
            end else if (!i_stuck[i] && cnt[i] < RAMP) begin
                cnt[i] <= cnt[i] + 1;
            end
        end
    end
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            o_mon[i] = (cnt[i] == RAMP);
        end
        // Unused monitors sit on the internal supply, so they read high
        o_mon[3:1] = o_mon[3:1] | i_unused;
    end
endmodule

// ---- testbench/seq_checker_assertions.sv ----
module seq_checker (
    input logic I_CLOCK,
    input logic I_SYS_RST,
    input logic I_POWER_ON_REQ,
    input logic I_POWER_OFF_REQ,
    input logic [3:0] I_RAIL_MONITOR_INPUT,
    input logic [2:0] I_CHANNEL_UNUSED,
    input logic [3:0] O_CHANNEL_ENABLE_OUTPUT,
    input logic O_SEQUENCE_COMPLETE_FLAG,
    input logic O_ALL_RAILS_GOOD_FLAG,
    input logic O_FAULT_N_OUT,
    input logic O_FAULT_N_OE,
    input logic O_WB_ACK,
    input logic [31:0] O_WB_DAT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (I_SYS_RST);
    logic [3:0] cov;
    assign cov = O_CHANNEL_ENABLE_OUTPUT | {I_CHANNEL_UNUSED, 1'b0};
    a_up_start: assert property ($rose(I_POWER_ON_REQ) && O_CHANNEL_ENABLE_OUTPUT == 4'h0
        && !O_FAULT_N_OE |-> ##[1:3] O_CHANNEL_ENABLE_OUTPUT[0]) else $error("no power-up");
    a_down_start: assert property ($fell(I_POWER_OFF_REQ) && O_CHANNEL_ENABLE_OUTPUT[3]
        |-> ##[1:3] !O_CHANNEL_ENABLE_OUTPUT[3]) else $error("no power-down");
    for (genvar k = 1; k < 4; k++) begin : g_ord
        // Predecessors must be on (or unused) and already regulated
        a_up_order: assert property ($rose(O_CHANNEL_ENABLE_OUTPUT[k]) |->
            (&cov[k-1:0]) && $past(&I_RAIL_MONITOR_INPUT[k-1:0])) else $error("bad up order");
    end
    a_down_order: assert property ($fell(O_CHANNEL_ENABLE_OUTPUT[0])
        |-> O_CHANNEL_ENABLE_OUTPUT[3:1] == 3'h0) else $error("bad down order");
    a_unused_off: assert property ((O_CHANNEL_ENABLE_OUTPUT[3:1] & I_CHANNEL_UNUSED) == 3'h0)
        else $error("unused channel enabled");
    a_done_state: assert property ($rose(O_SEQUENCE_COMPLETE_FLAG) |->
        O_CHANNEL_ENABLE_OUTPUT == 4'h0 || O_CHANNEL_ENABLE_OUTPUT == {~I_CHANNEL_UNUSED, 1'b1})
        else $error("done in wrong state");
    a_rails_good: assert property (!$past(I_SYS_RST) |->
        O_ALL_RAILS_GOOD_FLAG == $past(&I_RAIL_MONITOR_INPUT)) else $error("good flag wrong");
    a_fault_pin: assert property (!O_FAULT_N_OUT) else $error("fault pin driven high");
    a_fault_freeze: assert property ($rose(O_FAULT_N_OE) |->
        $stable(O_CHANNEL_ENABLE_OUTPUT) && !O_SEQUENCE_COMPLETE_FLAG) else $error("fault not frozen");
    a_ack_pulse: assert property (O_WB_ACK |=> !O_WB_ACK) else $error("ack too long");
    a_idle_data: assert property (!O_WB_ACK |-> O_WB_DAT == 32'h0) else $error("data outside ack");
    c_done: cover property ($rose(O_SEQUENCE_COMPLETE_FLAG));
    c_fault: cover property ($rose(O_FAULT_N_OE));
    c_down: cover property ($fell(O_CHANNEL_ENABLE_OUTPUT[0]));
endmodule

bind four_rail_power_sequencer seq_checker chk (.I_CLOCK, .I_SYS_RST, .I_POWER_ON_REQ,
    .I_POWER_OFF_REQ, .I_RAIL_MONITOR_INPUT, .I_CHANNEL_UNUSED, .O_CHANNEL_ENABLE_OUTPUT,
    .O_SEQUENCE_COMPLETE_FLAG, .O_ALL_RAILS_GOOD_FLAG, .O_FAULT_N_OUT, .O_FAULT_N_OE,
    .O_WB_ACK, .O_WB_DAT);

// ---- testbench/tb_four_rail_power_sequencer.sv ----
module tb_four_rail_power_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RAMP = 20;
    localparam int TK = pwr_seq_pkg::TICK_CYCLES;
    localparam int DLY = 250 * TK;
    localparam int LIMIT = 80000;
    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, on_req = 0, off_req = 1;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [3:0] sel = 4'h0, stuck = 4'h0, mon, en;
    logic [2:0] unused = 3'h0;
    logic ack, done, good, f_out, f_oe, irq;
    int err_total = 0, n_checks = 0, cycles = 0, c;
    initial begin
        forever #4 clk = ~clk;
    end
    rail_model #(.RAMP(RAMP)) rails (.i_clk(clk), .i_en(en), .i_unused(unused),
        .i_stuck(stuck), .o_mon(mon));
    four_rail_power_sequencer uut (.I_CLOCK(clk), .I_SYS_RST(rst), .I_WB_CYC(cyc),
        .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_DAT(wdat), .I_WB_SEL(sel),
        .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_POWER_ON_REQ(on_req), .I_POWER_OFF_REQ(off_req),
        .I_RAIL_MONITOR_INPUT(mon), .I_CHANNEL_UNUSED(unused), .O_CHANNEL_ENABLE_OUTPUT(en),
        .O_SEQUENCE_COMPLETE_FLAG(done), .O_ALL_RAILS_GOOD_FLAG(good), .O_FAULT_N_OUT(f_out),
        .O_FAULT_N_OE(f_oe), .O_IRQ(irq));
    task final_report();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Values are read in the active region at the edge, i.e. as the edge samples them
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        check("bus_ack", ack, 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask
    // Kind 0 waits for an enable pattern, 1 for completion, 2 for the fault
    task wait_until(input int k, input logic [3:0] v, input int max);
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (!((k == 0) ? en === v : (k == 1) ? done === 1'b1 : f_oe === 1'b1) && c < max);
        check("wait", c < max, 1'b1);
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            err_total++;
            final_report();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        xfer(0, pwr_seq_pkg::ADDR_STEP_DELAY, 0);
        check("step_rst", q, 32'h0);
        xfer(0, pwr_seq_pkg::ADDR_REG_TIMEOUT, 0);
        check("tmo_rst", q, 32'h0);
        xfer(0, pwr_seq_pkg::ADDR_IRQ_MASK, 0);
        check("mask_rst", q, 32'h0);
        xfer(0, 8'h14, 0);
        check("unmapped", q, 32'h0);
        check("en_rst", en, 4'h0);
        $display("test reset done");
        xfer(1, pwr_seq_pkg::ADDR_IRQ_MASK, 32'h0000_000F);
        on_req <= 1'b1;
        wait_until(0, 4'h1, 50);
        wait_until(0, 4'h3, 200);
        check("zero_delay", c <= RAMP + 6, 1'b1);
        wait_until(1, 4'h0, 500);
        check("en_up", en, 4'hF);
        check("good_up", good, 1'b1);
        xfer(0, pwr_seq_pkg::ADDR_STATUS, 0);
        check("status_up", q & 32'h0007_FF07, 32'h0003_FF03);
        check("irq_on", irq, 1'b1);
        xfer(0, pwr_seq_pkg::ADDR_IRQ_STATUS, 0);
        check("irq_up", q, 32'h1);
        check("irq_clr", irq, 1'b0);
        $display("test power-up done");
        xfer(1, pwr_seq_pkg::ADDR_IRQ_MASK, 0);
        on_req <= 1'b0;
        off_req <= 1'b0;
        wait_until(0, 4'h0, 200);
        wait_until(1, 4'h0, 50);
        check("good_down", good, 1'b0);
        check("irq_masked", irq, 1'b0);
        xfer(0, pwr_seq_pkg::ADDR_IRQ_STATUS, 0);
        check("irq_down", q, 32'hA);
        $display("test power-down done");
        xfer(1, pwr_seq_pkg::ADDR_STEP_DELAY, 250);
        unused <= 3'b110;
        off_req <= 1'b1;
        @(posedge clk);
        on_req <= 1'b1;
        wait_until(0, 4'h1, 50);
        wait_until(0, 4'h3, DLY + 500);
        check("delay_lo", c >= RAMP + DLY - TK - 2, 1'b1);
        check("delay_hi", c <= RAMP + DLY + 8, 1'b1);
        wait_until(1, 4'h0, 50);
        check("en_unused", en, 4'h3);
        check("good_unused", good, 1'b1);
        xfer(1, pwr_seq_pkg::ADDR_STEP_DELAY, 0);
        off_req <= 1'b0;
        wait_until(0, 4'h0, 100);
        // Let the done and rails-lost events land before the clearing read
        repeat (4) @(posedge clk);
        $display("test step delay done");
        xfer(0, pwr_seq_pkg::ADDR_IRQ_STATUS, 0);
        xfer(1, pwr_seq_pkg::ADDR_REG_TIMEOUT, 250);
        unused <= 3'b000;
        stuck <= 4'b0100;
        off_req <= 1'b1;
        on_req <= 1'b0;
        @(posedge clk);
        on_req <= 1'b1;
        wait_until(0, 4'h7, 500);
        wait_until(2, 4'h0, DLY + 500);
        check("tmo_lo", c >= DLY - TK - 2, 1'b1);
        check("tmo_hi", c <= DLY + 8, 1'b1);
        repeat (20) @(posedge clk);
        check("en_frozen", en, 4'h7);
        check("fault_pin", f_out, 1'b0);
        xfer(0, pwr_seq_pkg::ADDR_STATUS, 0);
        check("status_fault", q[18], 1'b1);
        xfer(0, pwr_seq_pkg::ADDR_IRQ_STATUS, 0);
        check("irq_fault", q, 32'h4);
        off_req <= 1'b0;
        wait_until(0, 4'h0, 100);
        $display("test timeout done");
        final_report();
    end
endmodule
